// [frmd_core.sv]
// file: decode and execute of the file-register move / OR instruction group
`timescale 1ns/1ps
module frmd_core
    import frmd_pkg::*;
#(
    parameter int DEPTH = frmd_pkg::MEM_DEPTH
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic insn_valid_i,
    input wire logic [frmd_pkg::INSN_W-1:0] insn_i,
    output logic insn_ready_o,
    output logic done_o,
    output logic illegal_o,
    output logic [frmd_pkg::DATA_W-1:0] working_o,
    output logic zero_o
);
    import frmd_pkg::*;

    initial begin
        if (DEPTH != (1 << ADDR_W)) $error("frmd_core: depth must match 5-bit file address");
    end

    // two phases: fetch operand (memory read is registered), then execute
    typedef enum logic [0:0] {
        FRMD_IDLE = 1'b0,
        FRMD_EXEC = 1'b1
    } frmd_state_e;

    frmd_state_e state_ff, nxt_state;
    logic [INSN_W-1:0] insn_ff;
    logic [DATA_W-1:0] working_ff, nxt_working;
    logic zero_ff, nxt_zero;
    logic done_ff, illegal_ff;

    frmd_mem_if #(.AW(ADDR_W), .DW(DATA_W)) mem ();

    frmd_file_mem #(.DEPTH(DEPTH), .DW(DATA_W)) u_mem (
        .clk_sys_i(clk_sys_i),
        .mem(mem)
    );

    // no-op shares its top bits with store and illegal words, so it is tested first
    function automatic frmd_op_e decode(input logic [INSN_W-1:0] w);
        if (w == INSN_NO_OPERATION) return FRMD_OP_NOP;
        if (w[OPC_MSB:OPC_LSB] == OPC_OR_WORKING_INTO_FILE) return FRMD_OP_OR;
        if (w[OPC_MSB:OPC_LSB] == OPC_MOVE_FILE_TO_DEST) return FRMD_OP_MOVE;
        if (w[OPC_MSB:DEST_BIT] == OPC_STORE_WORKING_TO_FILE) return FRMD_OP_STORE;
        if (w[LIT_OPC_MSB:LIT_OPC_LSB] == OPC_LOAD_LITERAL_TO_WORKING) return FRMD_OP_LOAD;
        return FRMD_OP_ILLEGAL;
    endfunction

    // decode of the held instruction
    wire frmd_op_e op = decode(insn_ff);
    wire logic dest_file = insn_ff[DEST_BIT];
    wire logic [ADDR_W-1:0] faddr = insn_ff[ADDR_W-1:0];
    wire logic [DATA_W-1:0] literal = insn_ff[DATA_W-1:0];
    wire logic [ADDR_W-1:0] in_addr = insn_i[ADDR_W-1:0];
    wire logic in_take = insn_valid_i && (state_ff == FRMD_IDLE);
    wire logic exec = (state_ff == FRMD_EXEC);
    wire logic [DATA_W-1:0] or_res = working_ff | mem.rd_data;
    wire logic [DATA_W-1:0] mv_res = mem.rd_data;

    // operand read is launched at the taking edge from the incoming word; a write
    // lands at the end of execute and no word is taken on that edge, so reads are fresh
    assign insn_ready_o = (state_ff == FRMD_IDLE);
    assign mem.rd_addr = in_addr;
    assign mem.wr_addr = faddr;

    // result routing: d selects working or file
    always_comb begin
        nxt_working = working_ff;
        nxt_zero = zero_ff;
        mem.wr_en = 1'b0;
        mem.wr_data = working_ff;
        if (exec) begin
            unique case (op)
                FRMD_OP_OR: begin
                    nxt_zero = (or_res == '0);
                    if (dest_file) begin
                        mem.wr_en = 1'b1;
                        mem.wr_data = or_res;
                    end else begin
                        nxt_working = or_res;
                    end
                end
                FRMD_OP_MOVE: begin
                    nxt_zero = (mv_res == '0);
                    if (dest_file) begin
                        mem.wr_en = 1'b1;
                        mem.wr_data = mv_res;
                    end else begin
                        nxt_working = mv_res;
                    end
                end
                FRMD_OP_STORE: begin
                    mem.wr_en = 1'b1;
                    mem.wr_data = working_ff;
                end
                FRMD_OP_LOAD: begin
                    nxt_working = literal; // flags untouched
                end
                FRMD_OP_NOP: begin
                    nxt_working = working_ff;
                end
                default: begin
                    nxt_working = working_ff; // outside this group: no effect
                end
            endcase
        end
    end

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            FRMD_IDLE: if (insn_valid_i) nxt_state = FRMD_EXEC;
            FRMD_EXEC: nxt_state = FRMD_IDLE;
        endcase
    end

    // state and architectural registers
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff <= FRMD_IDLE;
            insn_ff <= INSN_NO_OPERATION;
            working_ff <= WORKING_RST;
            zero_ff <= ZERO_RST;
            done_ff <= 1'b0;
            illegal_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            if (in_take) insn_ff <= insn_i;
            working_ff <= nxt_working;
            zero_ff <= nxt_zero;
            done_ff <= exec;
            illegal_ff <= exec && (op == FRMD_OP_ILLEGAL);
        end
    end

    assign working_o = working_ff;
    assign zero_o = zero_ff;
    assign done_o = done_ff;
    assign illegal_o = illegal_ff;

    // assertions
    sequence s_exec_or;
        exec && op == FRMD_OP_OR;
    endsequence
    sequence s_exec_move;
        exec && op == FRMD_OP_MOVE;
    endsequence

    AST_OR_ZERO: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        s_exec_or |=> zero_o == ($past(or_res) == 8'h00))
        else $error("or zero flag wrong");
    AST_OR_ONE_CYCLE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        in_take |=> exec ##1 done_o)
        else $error("instruction not done in one execute cycle");
    AST_OR_TO_W: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (s_exec_or and !dest_file) |=> working_o == $past(or_res))
        else $error("or result not in working");
    AST_OR_TO_F: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (s_exec_or and dest_file) |-> mem.wr_en && mem.wr_data == or_res && nxt_working == working_ff)
        else $error("or result not to file");
    AST_MOVE_DEST: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        s_exec_move |-> mem.wr_en == dest_file && mem.wr_addr == faddr)
        else $error("move destination wrong");
    AST_MOVE_TO_W: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (s_exec_move and !dest_file) |=> working_o == $past(mv_res))
        else $error("move value not in working");
    AST_MOVE_ZERO: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        s_exec_move |=> zero_o == ($past(mv_res) == 8'h00))
        else $error("move zero flag wrong");
    AST_STORE_FLAGS: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        exec && op == FRMD_OP_STORE |=> $stable(zero_o) && $stable(working_o))
        else $error("store changed flags or working");
    AST_NOP_QUIET: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        exec && op == FRMD_OP_NOP |-> !mem.wr_en ##1 ($stable(zero_o) && $stable(working_o)))
        else $error("no-op had an effect");

    // a taken word: one busy cycle, then the retire pulse
    sequence s_take_busy;
        in_take ##1 (exec && !insn_ready_o);
    endsequence
    sequence s_exec_store;
        exec && op == FRMD_OP_STORE;
    endsequence

    // timing of one instruction and the refusal of words while busy
    AST_RETIRE_PULSE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        s_take_busy |=> (done_o && insn_ready_o) ##1 !done_o)
        else $error("retire pulse wrong");
    AST_BUSY_HOLD: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        exec |=> $stable(insn_ff))
        else $error("word taken while busy");
    AST_IDLE_NO_WRITE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !exec |-> !mem.wr_en)
        else $error("file written outside execute");

    // destination side effects
    AST_OR_F_KEEP_W: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (s_exec_or and dest_file) |=> $stable(working_o))
        else $error("or to file changed working");
    AST_MOVE_F_KEEP_W: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (s_exec_move and dest_file) |=> $stable(working_o))
        else $error("move to file changed working");
    AST_MOVE_WB_ZERO: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (s_exec_move and dest_file) |-> (mem.wr_data == mem.rd_data)
            ##1 (zero_o == ($past(mem.rd_data) == 8'h00)))
        else $error("move write-back value or flag wrong");
    AST_STORE_WRITE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        s_exec_store |-> mem.wr_en && mem.wr_addr == faddr && mem.wr_data == working_o)
        else $error("store wrote wrong location or value");

    // load literal and words outside the group
    AST_LOAD_LIT: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        exec && op == FRMD_OP_LOAD |=> working_o == $past(literal) && $stable(zero_o))
        else $error("literal load wrong");
    AST_ILLEGAL_QUIET: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        exec && op == FRMD_OP_ILLEGAL |-> !mem.wr_en
            ##1 (illegal_o && $stable(zero_o) && $stable(working_o)))
        else $error("illegal word had an effect");
    AST_ILLEGAL_WITH_DONE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        illegal_o |-> done_o)
        else $error("illegal pulse without retire");
endmodule

// [frmd_pkg.sv]
// package: encodings, field positions and reset values for the file-op decoder
// What this block does
// - pattern 0001 00df ffff ORs working with file register, sets zero flag, one cycle.
// - OR result goes to working when d is 0, file register when 1.
// - pattern 0010 00df ffff copies file register to chosen destination in one cycle.
// - move result goes to working when d is 0, same file register when 1.
// - move updates zero flag from moved value, also when writing back.
package frmd_pkg;
    localparam int INSN_W = 12;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 5;
    localparam int DEST_BIT = 5;
    // opcode field occupies bits 11..6
    localparam int OPC_MSB = 11;
    localparam int OPC_LSB = 6;
    localparam int LIT_OPC_MSB = 11;
    localparam int LIT_OPC_LSB = 8;
    localparam logic [5:0] OPC_OR_WORKING_INTO_FILE = 6'h04;
    localparam logic [5:0] OPC_MOVE_FILE_TO_DEST = 6'h08;
    // store: bits 11..5 are 0000 001
    localparam logic [6:0] OPC_STORE_WORKING_TO_FILE = 7'h01;
    localparam logic [3:0] OPC_LOAD_LITERAL_TO_WORKING = 4'hC;
    localparam logic [11:0] INSN_NO_OPERATION = 12'h000;
    localparam logic [7:0] WORKING_RST = 8'h00;
    localparam logic ZERO_RST = 1'b0;
    localparam int MEM_DEPTH = 32;
    typedef enum logic [2:0] {
        FRMD_OP_NOP = 3'b000,
        FRMD_OP_OR = 3'b001,
        FRMD_OP_MOVE = 3'b010,
        FRMD_OP_STORE = 3'b011,
        FRMD_OP_LOAD = 3'b100,
        FRMD_OP_ILLEGAL = 3'b111
    } frmd_op_e;
endpackage

// [frmd_mem_if.sv]
// interface: file register memory port between core and storage
`timescale 1ns/1ps
interface frmd_mem_if #(parameter int AW = 5, parameter int DW = 8);
    logic [AW-1:0] rd_addr;
    logic [DW-1:0] rd_data;
    logic wr_en;
    logic [AW-1:0] wr_addr;
    logic [DW-1:0] wr_data;
    modport core (output rd_addr, input rd_data, output wr_en, output wr_addr, output wr_data);
    modport store (input rd_addr, output rd_data, input wr_en, input wr_addr, input wr_data);
endinterface

// [frmd_file_mem.sv]
// file: file register storage, registered read data
`timescale 1ns/1ps
module frmd_file_mem #(
    parameter int DEPTH = 32,
    parameter int DW = 8
) (
    input wire logic clk_sys_i,
    frmd_mem_if.store mem
);
    initial begin
        if (DEPTH < 2 || DW < 1) $error("frmd_file_mem: bad geometry");
    end
    logic [DW-1:0] store_ff [DEPTH];
    logic [DW-1:0] rd_data_ff;
    // registered read: data for an address appears one edge later
    always_ff @(posedge clk_sys_i) begin
        if (mem.wr_en) begin
            store_ff[mem.wr_addr] <= mem.wr_data;
        end
        rd_data_ff <= store_ff[mem.rd_addr];
    end
    assign mem.rd_data = rd_data_ff;
endmodule

// [file_register_move_or_decode_bench.sv]
// testbench: random instruction stream checked against an integer model
`timescale 1ns/1ps
module file_register_move_or_decode_bench;
    import frmd_pkg::*;
    logic clk_sys_i;
    logic rst_n_i;
    logic insn_valid_i;
    logic [INSN_W-1:0] insn_i;
    logic insn_ready_o;
    logic done_o;
    logic illegal_o;
    logic [DATA_W-1:0] working_o;
    logic zero_o;
    int fail_count;
    int checks;
    int seed;
    int wk;
    int zf;
    int mem [32];
    bit hung;

    frmd_core dut (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .insn_valid_i(insn_valid_i),
        .insn_i(insn_i),
        .insn_ready_o(insn_ready_o),
        .done_o(done_o),
        .illegal_o(illegal_o),
        .working_o(working_o),
        .zero_o(zero_o)
    );

    // free-running system clock, 10 ns period
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    task automatic close_out;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // offer one word, scramble insn_i while busy, then compare at done
    task automatic exec(input logic [11:0] w);
        int n;
        int f;
        int r;
        int ill;
        if (hung) return;
        f = w[4:0];
        ill = 0;
        n = 0;
        @(negedge clk_sys_i);
        insn_valid_i = 1'b1;
        insn_i = w;
        while (insn_ready_o !== 1'b1 && n < 20) begin
            @(negedge clk_sys_i);
            n++;
        end
        if (insn_ready_o !== 1'b1) begin
            // never accepted: count it and let the main sequence wind down
            $display("BAD ready expected 1 seen %b", insn_ready_o);
            fail_count++;
            hung = 1'b1;
            insn_valid_i = 1'b0;
            return;
        end
        @(negedge clk_sys_i);
        chk("ready", 8'h00, {7'h00, insn_ready_o});
        insn_i = 12'($random(seed)); // must be ignored while busy
        n = 0;
        while (done_o !== 1'b1 && n < 10) begin
            @(negedge clk_sys_i);
            n++;
        end
        insn_valid_i = 1'b0;
        if (done_o !== 1'b1) begin
            $display("BAD done expected 1 seen %b", done_o);
            fail_count++;
            hung = 1'b1;
            return;
        end
        // reference model of the instruction group
        if (w[11:6] == OPC_OR_WORKING_INTO_FILE) begin
            r = (wk | mem[f]) & 255;
            zf = (r == 0);
            if (w[5]) mem[f] = r; else wk = r;
        end else if (w[11:6] == OPC_MOVE_FILE_TO_DEST) begin
            r = mem[f];
            zf = (r == 0);
            if (w[5]) mem[f] = r; else wk = r;
        end else if (w[11:5] == OPC_STORE_WORKING_TO_FILE) begin
            mem[f] = wk;
        end else if (w[11:8] == OPC_LOAD_LITERAL_TO_WORKING) begin
            wk = w[7:0];
        end else if (w != INSN_NO_OPERATION) begin
            ill = 1;
        end
        chk("illegal", 8'(ill), {7'h00, illegal_o});
        chk("working", 8'(wk), working_o);
        chk("zero", 8'(zf), {7'h00, zero_o});
    endtask

    // main sequence: reset, fill file, random mix, reset again
    initial begin
        int k;
        int f;
        int lit;
        logic [11:0] w;
        seed = 32'h5338;
        hung = 1'b0;
        rst_n_i = 1'b0;
        insn_valid_i = 1'b0;
        insn_i = 12'h000;
        wk = 0;
        zf = 0;
        repeat (2) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        chk("working", WORKING_RST, working_o);
        chk("ready", 8'h01, {7'h00, insn_ready_o});
        chk("zero", 8'(ZERO_RST), {7'h00, zero_o});
        // file is unknown after reset, so give every location a value
        for (f = 0; f < 32; f++) begin
            exec(12'hC00 | 12'(f * 37 & 255));
            exec(12'h020 | 12'(f));
        end
        for (int i = 0; i < 400; i++) begin
            k = $random(seed) & 7;
            f = $random(seed) & 31;
            lit = $random(seed) & 255;
            if (lit < 80) lit = 0; // zeros exercise the flag often
            case (k)
                0: w = 12'h100 | 12'(lit & 32) | 12'(f);
                1: w = 12'h200 | 12'(lit & 32) | 12'(f);
                2: w = 12'h020 | 12'(f);
                3, 4: w = 12'hC00 | 12'(lit);
                5: w = 12'h000;
                6: w = 12'hF00 | 12'(lit);
                default: w = 12'h001 + 12'(f % 31);
            endcase
            exec(w);
        end
        // reset in mid-run restores working and flag
        @(negedge clk_sys_i);
        rst_n_i = 1'b0;
        @(negedge clk_sys_i);
        chk("working", WORKING_RST, working_o);
        chk("zero", 8'(ZERO_RST), {7'h00, zero_o});
        chk("ready", 8'h01, {7'h00, insn_ready_o});
        rst_n_i = 1'b1;
        wk = 0;
        zf = 0;
        exec(12'hC3C);
        exec(12'h027);
        exec(12'h207);
        close_out();
    end
endmodule
